// File: rtl/cmp_map.vh
// register offsets, field positions, reset values and encodings of the dual comparator
`ifndef CMP_MAP_VH
`define CMP_MAP_VH

// register offsets (4-bit word address)
`define CMP_ADDR_W 4
`define CMP_OFF_CTRL_A0 4'h0
`define CMP_OFF_CTRL_B0 4'h1
`define CMP_OFF_CTRL_A1 4'h2
`define CMP_OFF_CTRL_B1 4'h3
`define CMP_OFF_SHARED_OUT 4'h4
`define CMP_OFF_FLAG 4'h5
`define CMP_OFF_IRQ_EN 4'h6
`define CMP_OFF_IRQ_CTRL 4'h7
`define CMP_OFF_ANALOG_SEL 4'h8
`define CMP_OFF_PORT_DATA 4'h9
`define CMP_OFF_SHDN_EN 4'hA

// control register a fields
`define CMP_A_ENABLE 7
`define CMP_A_STATUS 6
`define CMP_A_INVERT 4
`define CMP_A_SPEED 2
`define CMP_A_HYS 1
`define CMP_A_SYNC 0

// control register b fields
`define CMP_B_RISE 7
`define CMP_B_FALL 6
`define CMP_B_PCH_HI 5
`define CMP_B_PCH_LO 3
`define CMP_B_NCH_HI 2
`define CMP_B_NCH_LO 0

// irq control fields
`define CMP_IC_GLOBAL 7
`define CMP_IC_PERIPH 6

// reset values
`define CMP_RST_ENABLE 1'b0
`define CMP_RST_SPEED 1'b1
`define CMP_RST_BYTE 8'h00

// positive channel codes
`define CMP_PCH_PIN 3'h0
`define CMP_PCH_DAC 3'h1
`define CMP_PCH_FVR 3'h2
`define CMP_PCH_VSS 3'h3

// negative channel codes
`define CMP_NCH_PIN 3'h0
`define CMP_NCH_FVR 3'h1
`define CMP_NCH_AGND 3'h2

`endif

// File: rtl/cmp_channel.v
// one comparator: input routing, polarity, timer sync, latch and edge detect
`timescale 1ns/100ps
`include "cmp_map.vh"

module cmp_channel (
	// clock and reset
	input wire mclk,
	input wire rst,
	// configuration
	input wire enable,
	input wire invert,
	input wire hys_en,
	input wire sync_en,
	input wire rise_en,
	input wire fall_en,
	input wire [2:0] pos_sel,
	input wire [2:0] neg_sel,
	// analog result and timer edge
	input wire cmp_raw,
	input wire tmr_fall,
	// results
	output wire final_out,
	output reg out_q,
	output wire edge_hit,
	// analog controls
	output wire [3:0] pos_route,
	output wire [2:0] neg_route,
	output wire bias_on,
	output wire hyst_on
);

	reg sync_cap_q;
	wire [3:0] neg_full;
	wire adj;
	wire rise;
	wire fall;

	// one-hot switch decode; disabled comparator opens every switch
	function [3:0] route_dec;
		input en;
		input [2:0] sel;
		input [2:0] c0;
		input [2:0] c1;
		input [2:0] c2;
		input [2:0] c3;
		begin
			route_dec = 4'h0;
			if (en) begin
				route_dec[0] = (sel == c0);
				route_dec[1] = (sel == c1);
				route_dec[2] = (sel == c2);
				route_dec[3] = (sel == c3);
			end
		end
	endfunction

	// input switches, positive and negative
	assign pos_route = route_dec(enable, pos_sel, `CMP_PCH_PIN, `CMP_PCH_DAC,
		`CMP_PCH_FVR, `CMP_PCH_VSS);
	// negative side has three sources; code 7 lands in the dropped fourth slot
	assign neg_full = route_dec(enable, neg_sel, `CMP_NCH_PIN, `CMP_NCH_FVR,
		`CMP_NCH_AGND, 3'h7);
	assign neg_route = neg_full[2:0];

	// analog power and hysteresis only while enabled
	assign bias_on = enable;
	assign hyst_on = enable & hys_en;

	// raw result high when + exceeds -; off comparator reads the invert bit
	assign adj = (enable & cmp_raw) ^ invert;

	// capture on falling edge of gate timer source clock
	always @(posedge mclk) begin
		if (rst) begin
			sync_cap_q <= 1'b0;
		end else if (tmr_fall) begin
			sync_cap_q <= adj;
		end
	end

	// unlatched output for pin, timer gate and shutdown
	assign final_out = sync_en ? sync_cap_q : adj;

	// internal copy latched each instruction cycle
	always @(posedge mclk) begin
		if (rst) begin
			out_q <= 1'b0;
		end else begin
			out_q <= final_out;
		end
	end

	// edge detect against previous cycle value
	assign rise = final_out & ~out_q;
	assign fall = ~final_out & out_q;
	assign edge_hit = (rise & rise_en) | (fall & fall_en);

endmodule

// File: rtl/dual_cmp.v
// dual comparator digital control: registers, flags, routing and shutdown
//
// What this block does
// - two independent comparators with own controls
// - comparator runs only while enabled
// - raw result high when plus exceeds minus
// - invert bit XORs the raw result
// - output readable in control and shared registers
// - internal output latched each cycle, pin not
// - sync bit captures on timer clock fall
// - output offered as gate timer gate source
// - enabled rising or falling edge sets flag
// - software clears flag; new edge wins
// - invert or enable toggles count as edges
// - positive select: pin, DAC, reference, ground
// - negative select: pin, reference, analog ground
// - disabled comparator opens all input switches
// - hysteresis follows its enable bit while the comparator is enabled
// - analog pins read zero on port read
// - active output with shutdown enable suspends generator
// - pending interrupt wakes; sync stops in sleep when the timer runs on system clock
`timescale 1ns/100ps
`include "cmp_map.vh"

module dual_cmp #(
	parameter PORT_W = 8
) (
	// clock and reset
	input wire mclk,
	input wire rst,
	// register port
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// analog comparison results, one per comparator
	input wire [1:0] cmp_raw,
	// gate timer source clock and sleep state
	input wire tmr_src_clk,
	input wire tmr_clk_is_sys,
	input wire sleep,
	// digital port pins
	input wire [PORT_W-1:0] port_pins,
	// comparator outputs
	output wire [1:0] cmp_pin_out,
	output wire [1:0] gate_timer_src,
	// analog switch controls
	output wire [3:0] pos_route0,
	output wire [2:0] neg_route0,
	output wire [3:0] pos_route1,
	output wire [2:0] neg_route1,
	output wire [1:0] bias_on,
	output wire [1:0] hyst_on,
	output wire [1:0] speed_power_select,
	// system events
	output wire waveform_suspend,
	output wire cmp_irq,
	output wire wake
);

	// writable control bits, one bit per comparator; channel selects three bits each
	reg [1:0] enable_q;
	reg [1:0] invert_q;
	reg [1:0] speed_q;
	reg [1:0] hys_q;
	reg [1:0] sync_q;
	reg [1:0] rise_en_q;
	reg [1:0] fall_en_q;
	reg [2:0] pch0_q;
	reg [2:0] pch1_q;
	reg [2:0] nch0_q;
	reg [2:0] nch1_q;
	// interrupt and system registers
	reg [1:0] flag_q;
	reg [1:0] flag_d;
	reg [1:0] irq_en_q;
	reg global_en_q;
	reg periph_en_q;
	reg [PORT_W-1:0] analog_sel_q;
	reg [1:0] shdn_en_q;
	reg [7:0] rdata_d;
	// timer clock edge detect
	reg tmr_prev_q;
	wire tmr_fall;
	// channel results
	wire [1:0] final_out;
	wire [1:0] out_q;
	wire [1:0] edge_hit;
	wire [1:0] pending;

	// pack control register a of one comparator
	function [7:0] pack_a;
		input en;
		input status;
		input inv;
		input sp;
		input hys;
		input syn;
		begin
			pack_a = 8'h00;
			pack_a[`CMP_A_ENABLE] = en;
			pack_a[`CMP_A_STATUS] = status;
			pack_a[`CMP_A_INVERT] = inv;
			pack_a[`CMP_A_SPEED] = sp;
			pack_a[`CMP_A_HYS] = hys;
			pack_a[`CMP_A_SYNC] = syn;
		end
	endfunction

	// pack control register b of one comparator
	function [7:0] pack_b;
		input rise;
		input fall;
		input [2:0] pch;
		input [2:0] nch;
		begin
			pack_b = 8'h00;
			pack_b[`CMP_B_RISE] = rise;
			pack_b[`CMP_B_FALL] = fall;
			pack_b[`CMP_B_PCH_HI:`CMP_B_PCH_LO] = pch;
			pack_b[`CMP_B_NCH_HI:`CMP_B_NCH_LO] = nch;
		end
	endfunction

	// falling edge of timer clock; held off in sleep on system clock
	always @(posedge mclk) begin
		if (rst) begin
			tmr_prev_q <= 1'b0;
		end else begin
			tmr_prev_q <= tmr_src_clk;
		end
	end
	assign tmr_fall = tmr_prev_q & ~tmr_src_clk & ~(sleep & tmr_clk_is_sys);

	// comparator 0
	cmp_channel u_cmp0 (
		.mclk(mclk),
		.rst(rst),
		.enable(enable_q[0]),
		.invert(invert_q[0]),
		.hys_en(hys_q[0]),
		.sync_en(sync_q[0]),
		.rise_en(rise_en_q[0]),
		.fall_en(fall_en_q[0]),
		.pos_sel(pch0_q),
		.neg_sel(nch0_q),
		.cmp_raw(cmp_raw[0]),
		.tmr_fall(tmr_fall),
		.final_out(final_out[0]),
		.out_q(out_q[0]),
		.edge_hit(edge_hit[0]),
		.pos_route(pos_route0),
		.neg_route(neg_route0),
		.bias_on(bias_on[0]),
		.hyst_on(hyst_on[0])
	);

	// comparator 1, fully independent of comparator 0
	cmp_channel u_cmp1 (
		.mclk(mclk),
		.rst(rst),
		.enable(enable_q[1]),
		.invert(invert_q[1]),
		.hys_en(hys_q[1]),
		.sync_en(sync_q[1]),
		.rise_en(rise_en_q[1]),
		.fall_en(fall_en_q[1]),
		.pos_sel(pch1_q),
		.neg_sel(nch1_q),
		.cmp_raw(cmp_raw[1]),
		.tmr_fall(tmr_fall),
		.final_out(final_out[1]),
		.out_q(out_q[1]),
		.edge_hit(edge_hit[1]),
		.pos_route(pos_route1),
		.neg_route(neg_route1),
		.bias_on(bias_on[1]),
		.hyst_on(hyst_on[1])
	);

	// pin output and timer gate take the unlatched output
	assign cmp_pin_out = final_out;
	assign gate_timer_src = final_out;
	assign speed_power_select = speed_q;

	// immediate generator shutdown from active output
	assign waveform_suspend = |(final_out & shdn_en_q);

	// interrupt request and wake from pending enabled flags
	assign pending = flag_q & irq_en_q;
	assign cmp_irq = global_en_q & periph_en_q & (|pending);
	assign wake = sleep & (|pending);

	// flag next value: a hardware edge beats a clearing write
	always @* begin
		flag_d = flag_q;
		if (reg_wr && reg_addr == `CMP_OFF_FLAG) begin
			flag_d = reg_wdata[1:0];
		end
		flag_d = flag_d | edge_hit;
	end

	// flag register
	always @(posedge mclk) begin
		if (rst) begin
			flag_q <= 2'b00;
		end else begin
			flag_q <= flag_d;
		end
	end

	// control register a writes
	always @(posedge mclk) begin
		if (rst) begin
			enable_q <= {2{`CMP_RST_ENABLE}};
			invert_q <= 2'b00;
			speed_q <= {2{`CMP_RST_SPEED}};
			hys_q <= 2'b00;
			sync_q <= 2'b00;
		end else if (reg_wr && reg_addr == `CMP_OFF_CTRL_A0) begin
			enable_q[0] <= reg_wdata[`CMP_A_ENABLE];
			invert_q[0] <= reg_wdata[`CMP_A_INVERT];
			speed_q[0] <= reg_wdata[`CMP_A_SPEED];
			hys_q[0] <= reg_wdata[`CMP_A_HYS];
			sync_q[0] <= reg_wdata[`CMP_A_SYNC];
		end else if (reg_wr && reg_addr == `CMP_OFF_CTRL_A1) begin
			enable_q[1] <= reg_wdata[`CMP_A_ENABLE];
			invert_q[1] <= reg_wdata[`CMP_A_INVERT];
			speed_q[1] <= reg_wdata[`CMP_A_SPEED];
			hys_q[1] <= reg_wdata[`CMP_A_HYS];
			sync_q[1] <= reg_wdata[`CMP_A_SYNC];
		end
	end

	// control register b writes
	always @(posedge mclk) begin
		if (rst) begin
			rise_en_q <= 2'b00;
			fall_en_q <= 2'b00;
			pch0_q <= 3'h0;
			pch1_q <= 3'h0;
			nch0_q <= 3'h0;
			nch1_q <= 3'h0;
		end else if (reg_wr && reg_addr == `CMP_OFF_CTRL_B0) begin
			rise_en_q[0] <= reg_wdata[`CMP_B_RISE];
			fall_en_q[0] <= reg_wdata[`CMP_B_FALL];
			pch0_q <= reg_wdata[`CMP_B_PCH_HI:`CMP_B_PCH_LO];
			nch0_q <= reg_wdata[`CMP_B_NCH_HI:`CMP_B_NCH_LO];
		end else if (reg_wr && reg_addr == `CMP_OFF_CTRL_B1) begin
			rise_en_q[1] <= reg_wdata[`CMP_B_RISE];
			fall_en_q[1] <= reg_wdata[`CMP_B_FALL];
			pch1_q <= reg_wdata[`CMP_B_PCH_HI:`CMP_B_PCH_LO];
			nch1_q <= reg_wdata[`CMP_B_NCH_HI:`CMP_B_NCH_LO];
		end
	end

	// interrupt enables, analog select and shutdown enables
	always @(posedge mclk) begin
		if (rst) begin
			irq_en_q <= 2'b00;
			global_en_q <= 1'b0;
			periph_en_q <= 1'b0;
			analog_sel_q <= {PORT_W{1'b0}};
			shdn_en_q <= 2'b00;
		end else if (reg_wr) begin
			case (reg_addr)
				`CMP_OFF_IRQ_EN: begin
					irq_en_q <= reg_wdata[1:0];
				end
				`CMP_OFF_IRQ_CTRL: begin
					global_en_q <= reg_wdata[`CMP_IC_GLOBAL];
					periph_en_q <= reg_wdata[`CMP_IC_PERIPH];
				end
				`CMP_OFF_ANALOG_SEL: begin
					analog_sel_q <= reg_wdata[PORT_W-1:0];
				end
				`CMP_OFF_SHDN_EN: begin
					shdn_en_q <= reg_wdata[1:0];
				end
				default: begin
					irq_en_q <= irq_en_q;
				end
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	always @* begin
		rdata_d = `CMP_RST_BYTE;
		case (reg_addr)
			`CMP_OFF_CTRL_A0: begin
				rdata_d = pack_a(enable_q[0], out_q[0], invert_q[0], speed_q[0],
					hys_q[0], sync_q[0]);
			end
			`CMP_OFF_CTRL_B0: begin
				rdata_d = pack_b(rise_en_q[0], fall_en_q[0], pch0_q, nch0_q);
			end
			`CMP_OFF_CTRL_A1: begin
				rdata_d = pack_a(enable_q[1], out_q[1], invert_q[1], speed_q[1],
					hys_q[1], sync_q[1]);
			end
			`CMP_OFF_CTRL_B1: begin
				rdata_d = pack_b(rise_en_q[1], fall_en_q[1], pch1_q, nch1_q);
			end
			`CMP_OFF_SHARED_OUT: begin
				rdata_d[1:0] = out_q;
			end
			`CMP_OFF_FLAG: begin
				rdata_d[1:0] = flag_q;
			end
			`CMP_OFF_IRQ_EN: begin
				rdata_d[1:0] = irq_en_q;
			end
			`CMP_OFF_IRQ_CTRL: begin
				rdata_d[`CMP_IC_GLOBAL] = global_en_q;
				rdata_d[`CMP_IC_PERIPH] = periph_en_q;
			end
			`CMP_OFF_ANALOG_SEL: begin
				rdata_d[PORT_W-1:0] = analog_sel_q;
			end
			`CMP_OFF_PORT_DATA: begin
				rdata_d[PORT_W-1:0] = port_pins & ~analog_sel_q;
			end
			`CMP_OFF_SHDN_EN: begin
				rdata_d[1:0] = shdn_en_q;
			end
			default: begin
				rdata_d = `CMP_RST_BYTE;
			end
		endcase
	end

	// read data valid only in the cycle after the strobe
	always @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= `CMP_RST_BYTE;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= `CMP_RST_BYTE;
		end
	end

endmodule

// File: verification/dual_cmp_asserts.sv
// port-level checks for the dual comparator block
`timescale 1ns/100ps
module dual_cmp_asserts (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] reg_rdata,
	// outputs and sleep
	input wire logic sleep,
	input wire logic [1:0] cmp_pin_out,
	input wire logic [1:0] gate_timer_src,
	input wire logic [3:0] pos_route0,
	input wire logic [2:0] neg_route0,
	input wire logic [3:0] pos_route1,
	input wire logic [2:0] neg_route1,
	input wire logic [1:0] bias_on,
	input wire logic [1:0] hyst_on,
	input wire logic waveform_suspend,
	input wire logic cmp_irq,
	input wire logic wake
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// timer gate source and pin carry the same output
	gate_src_a: assert property (gate_timer_src == cmp_pin_out)
		else $error("gate source differs from pin output");
	// shared register returns the output latched one cycle before the read
	status_read_a: assert property (reg_rd && reg_addr == 4'h4 |=>
		reg_rdata == {6'h00, $past(cmp_pin_out, 2)}) else $error("shared output read wrong");
	// a disabled comparator has every switch open
	route_off_a: assert property ((bias_on[0] || pos_route0 == 4'h0 && neg_route0 == 3'h0) &&
		(bias_on[1] || pos_route1 == 4'h0 && neg_route1 == 3'h0)) else $error("switch closed");
	// at most one source per input
	route_onehot_a: assert property ($onehot0(pos_route0) && $onehot0(neg_route0) &&
		$onehot0(pos_route1) && $onehot0(neg_route1))
		else $error("two sources on one input");
	// hysteresis only on an enabled comparator
	hyst_gate_a: assert property ((hyst_on & ~bias_on) == 2'h0)
		else $error("hysteresis on a disabled comparator");
	// only a write may drop a pending request
	flag_hold_a: assert property (cmp_irq && !reg_wr |=> cmp_irq)
		else $error("request dropped without a write");
	// wake only in sleep, and always while asleep with a pending request
	wake_rel_a: assert property (wake ? sleep : !(sleep && cmp_irq))
		else $error("wake mismatch");
	// suspend needs an active output
	suspend_src_a: assert property (waveform_suspend |-> cmp_pin_out != 2'h0)
		else $error("suspend without active output");
	// main scenarios
	irq_c: cover property (cmp_irq);
	wake_c: cover property (wake);
	suspend_c: cover property (waveform_suspend);
endmodule

bind dual_cmp dual_cmp_asserts dual_cmp_asserts_inst (.mclk(mclk), .rst(rst),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
	.sleep(sleep), .cmp_pin_out(cmp_pin_out), .gate_timer_src(gate_timer_src),
	.pos_route0(pos_route0), .neg_route0(neg_route0), .pos_route1(pos_route1),
	.neg_route1(neg_route1), .bias_on(bias_on), .hyst_on(hyst_on),
	.waveform_suspend(waveform_suspend), .cmp_irq(cmp_irq), .wake(wake));

// File: verification/analog_side.sv
// analog results and gate timer source clock facing the comparator block
`timescale 1ns/100ps
module analog_side (
	// clock
	input wire logic mclk,
	// requested comparison, response speed, timer activity
	input wire logic [1:0] level,
	input wire logic slow,
	input wire logic tmr_run,
	// towards the block
	output logic [1:0] cmp_raw = 2'h0,
	output logic tmr_src_clk = 1'b0
);
	logic [1:0] stage_q = 2'h0;
	logic [1:0] div_q = 2'h0;
	// result is high when plus is above minus, after one or two cycles
	always @(posedge mclk) begin
		stage_q <= level;
		cmp_raw <= slow ? stage_q : level;
	end
	// timer clock stands still at low while the timer is stopped
	always @(posedge mclk) begin
		div_q <= tmr_run ? div_q + 2'h1 : 2'h0;
		tmr_src_clk <= tmr_run & div_q[1];
	end
endmodule

// File: verification/dual_cmp_bench.sv
// self-checking bench for the dual comparator block
`timescale 1ns/100ps
module dual_cmp_bench;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sleep = 1'b0;
	logic [7:0] port_pins = 8'h00;
	logic [1:0] level = 2'h0;
	logic slow = 1'b0;
	logic tmr_run = 1'b0;
	logic tmr_sys = 1'b0;
	wire [1:0] gate_src;
	wire [7:0] reg_rdata;
	wire [1:0] cmp_raw, cmp_pin_out, bias_on, hyst_on, speed_power_select;
	wire [3:0] pos_route0, pos_route1;
	wire [2:0] neg_route0, neg_route1;
	wire tmr_src_clk, waveform_suspend, cmp_irq, wake;
	int failures = 0;
	int cmp_count = 0;
	int i;
	// 25 MHz clock
	always #20 mclk = ~mclk;
	// block and its analog partner
	dual_cmp #(.PORT_W(8)) dual_cmp_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cmp_raw(cmp_raw), .tmr_src_clk(tmr_src_clk), .tmr_clk_is_sys(tmr_sys), .sleep(sleep),
		.port_pins(port_pins), .cmp_pin_out(cmp_pin_out), .gate_timer_src(gate_src),
		.pos_route0(pos_route0), .neg_route0(neg_route0), .pos_route1(pos_route1),
		.neg_route1(neg_route1), .bias_on(bias_on), .hyst_on(hyst_on),
		.speed_power_select(speed_power_select), .waveform_suspend(waveform_suspend),
		.cmp_irq(cmp_irq), .wake(wake));
	analog_side analog_side_inst (.mclk(mclk), .level(level), .slow(slow),
		.tmr_run(tmr_run), .cmp_raw(cmp_raw), .tmr_src_clk(tmr_src_clk));
	// bus and compare helpers
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk($sformatf("reg %h", a), exp, reg_rdata);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic wait_out(input logic v);
		@(negedge mclk);
		for (int k = 0; k < 20 && cmp_pin_out[0] !== v; k++) @(negedge mclk);
		chk("sync out", {7'h00, v}, {7'h00, cmp_pin_out[0]});
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (100000) @(posedge mclk);
		failures++;
		close_out;
	end
	// main sequence
	initial begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		rd(4'h0, 8'h04);
		rd(4'h2, 8'h04);
		rd(4'hF, 8'h00);
		chk("speed", 8'h03, {6'h00, speed_power_select});
		wr(4'h0, 8'h84);
		for (i = 0; i < 4; i++) begin
			wr(4'h1, {2'h0, i[2:0], i[2:0]});
			tick(0);
			chk("pos route", 8'h01 << i, {4'h0, pos_route0});
			chk("neg route", (i < 3) ? 8'h01 << i : 8'h00, {5'h00, neg_route0});
		end
		wr(4'h0, 8'h04);
		tick(0);
		chk("routes off", 8'h00, {pos_route0, neg_route0, bias_on[0]});
		for (i = 0; i < 4; i++) begin
			wr(4'h0, {3'h4, i[1], 4'h4});
			level <= {1'b0, i[0]};
			tick(3);
			chk("pin out", {7'h00, i[0] ^ i[1]}, {6'h00, cmp_pin_out});
			rd(4'h4, {7'h00, i[0] ^ i[1]});
			rd(4'h0, {1'b1, i[0] ^ i[1], 1'b0, i[1], 4'h4});
		end
		// both edges enabled, full request chain, then sleep and mask
		wr(4'h6, 8'h01);
		wr(4'h7, 8'hC0);
		wr(4'h1, 8'hC0);
		wr(4'h0, 8'h84);
		wr(4'h5, 8'h00);
		sleep <= 1'b1;
		level <= 2'h0;
		tick(3);
		chk("irq wake", 8'h03, {6'h00, cmp_irq, wake});
		rd(4'h5, 8'h01);
		wr(4'h6, 8'h00);
		tick(0);
		chk("masked", 8'h00, {6'h00, cmp_irq, wake});
		// invert flip while disabled, then an edge on the clearing write
		wr(4'h5, 8'h00);
		wr(4'h0, 8'h14);
		tick(2);
		rd(4'h5, 8'h01);
		wr(4'h0, 8'h84);
		wr(4'h5, 8'h00);
		level <= 2'h1;
		wr(4'h5, 8'h00);
		rd(4'h5, 8'h01);
		// output follows only on timer clock falls, slow partner
		slow <= 1'b1;
		wr(4'h0, 8'h85);
		tmr_run <= 1'b1;
		wait_out(1'b1);
		tmr_run <= 1'b0;
		tick(3);
		level <= 2'h0;
		tick(6);
		chk("held", 8'h01, {7'h00, cmp_pin_out[0]});
		// timer on the system clock while asleep: no capture at all
		@(posedge mclk);
		tmr_sys <= 1'b1;
		tmr_run <= 1'b1;
		tick(12);
		chk("sleep hold", 8'h01, {7'h00, cmp_pin_out[0]});
		@(posedge mclk);
		tmr_sys <= 1'b0;
		tmr_run <= 1'b1;
		wait_out(1'b0);
		tmr_run <= 1'b0;
		wr(4'hA, 8'h01);
		tick(0);
		chk("no suspend", 8'h00, {7'h00, waveform_suspend});
		wr(4'h0, 8'h94);
		tick(0);
		chk("suspend", 8'h01, {7'h00, waveform_suspend});
		chk("gate src", 8'h01, {6'h00, gate_src});
		wr(4'h2, 8'h86);
		tick(0);
		chk("hyst bias", 8'h0B, {4'h0, hyst_on, bias_on});
		chk("routes 1", 8'h09, {1'b0, pos_route1, neg_route1});
		@(posedge mclk);
		port_pins <= 8'hFF;
		wr(4'h8, 8'h0F);
		rd(4'h9, 8'hF0);
		close_out;
	end
endmodule
